// file: logic/squib_diag_regs.svh
`ifndef SQUIB_DIAG_REGS_SVH
`define SQUIB_DIAG_REGS_SVH

`define CMD_THERMAL 8'h7F
`define CMD_UNLOCK_HIGH 8'h82
`define CMD_UNLOCK_LOW 8'h83
`define SEL_HIGH_NIBBLE 4'h1
`define SEL_LOW_NIBBLE 4'h2
`define FRAME_BITS 4'h8
`define REPLY_IDLE_BYTE 8'h00
`define THERM_MIN_NS 2090000
`define THERM_MAX_NS 2820000
`define CLOCK_PERIOD_NS 8
`define THERM_MIN_CYCLES ((`THERM_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define THERM_MAX_CYCLES (`THERM_MAX_NS / `CLOCK_PERIOD_NS)
`define ON_COUNT_WIDTH 20
`endif

// file: logic/squib_diag_pkg.sv
package squib_diag_pkg;
  typedef enum logic [1:0] {
    REPLY_IDLE,
    REPLY_ECHO,
    REPLY_THERMAL,
    REPLY_TEST
  } reply_kind_t;

  typedef enum logic [1:0] {
    UNLOCK_NONE,
    UNLOCK_HIGH,
    UNLOCK_LOW
  } unlock_state_t;

  // per-channel test bits, high side in the upper nibble
  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } chan_test_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } frame_t;
endpackage

// file: logic/on_time_guard.sv
`include "squib_diag_regs.svh"
module on_time_guard
  import squib_diag_pkg::*;
#(
  parameter int MIN_CYCLES = `THERM_MIN_CYCLES,
  parameter int MAX_CYCLES = `THERM_MAX_CYCLES,
  parameter int WIDTH = `ON_COUNT_WIDTH
)
(
  // clock and clear
  input wire logic clk,
  input wire logic clear,
  // driver state
  input wire logic drive_on,
  input wire logic overtemp,
  input wire logic shorted_load,
  // result
  output logic shutdown
);
  logic [WIDTH-1:0] on_count;
  logic min_reached;
  logic max_reached;

  assign min_reached = on_count >= WIDTH'(MIN_CYCLES);
  assign max_reached = on_count >= WIDTH'(MAX_CYCLES);

  always_ff @(posedge clk)
  begin
    if (clear || !drive_on)
      on_count <= '0;
    else if (!max_reached)
      on_count <= on_count + WIDTH'(1);
  end

  always_ff @(posedge clk)
  begin
    if (clear || !drive_on)
      shutdown <= 1'b0;
    else if ((overtemp && min_reached) || (shorted_load && max_reached))
      shutdown <= 1'b1;
  end
endmodule

// file: logic/squib_diag.sv
`include "squib_diag_regs.svh"
module squib_diag
  import squib_diag_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int THERM_MIN_CYCLES = `THERM_MIN_CYCLES,
  parameter int THERM_MAX_CYCLES = `THERM_MAX_CYCLES
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic RESET_PIN_N,
  // serial port, sampled on CLOCK
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  // fire enables
  input wire logic FIRE_ENABLE_IN_ONE,
  input wire logic FIRE_ENABLE_IN_TWO,
  // firing request and analog status per channel
  input wire logic [CHANNELS-1:0] FIRE_CMD,
  input wire logic [CHANNELS-1:0] OVERTEMP,
  input wire logic [CHANNELS-1:0] SHORTED_LOAD,
  input wire logic [CHANNELS-1:0] HIGH_SIDE_ON_SENSE,
  input wire logic [CHANNELS-1:0] LOW_SIDE_ON_SENSE,
  // driver controls
  output logic [CHANNELS-1:0] DRIVE_ON,
  output logic [CHANNELS-1:0] HIGH_SIDE_TEST_EN,
  output logic [CHANNELS-1:0] LOW_SIDE_TEST_EN,
  output logic TEST_CURRENT_LIMIT,
  // status
  output logic [CHANNELS-1:0] THERMAL_STATUS,
  output logic DIAG_BLOCKED
);
  logic clear;
  logic fire_enabled;
  logic fire_any;
  logic sclk_prev;
  logic cs_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic [7:0] rx_shift;
  logic [3:0] bit_count;
  logic [7:0] tx_shift;
  frame_t frame;
  reply_kind_t reply_kind;
  reply_kind_t reply_now;
  logic [7:0] echo_byte;
  logic [7:0] reply_byte;
  unlock_state_t unlock_state;
  logic [CHANNELS-1:0] thermal_flag;
  logic [CHANNELS-1:0] thermal_latch;
  logic [CHANNELS-1:0] shutdown;
  chan_test_t test_active;
  chan_test_t test_fail;
  logic unlock_ok;
  logic sel_high_ok;
  logic sel_low_ok;

  function automatic logic is_unlock(input logic [7:0] b);
    is_unlock = (b == `CMD_UNLOCK_HIGH) || (b == `CMD_UNLOCK_LOW);
  endfunction

  function automatic logic is_select(input logic [7:0] b, input logic [3:0] nib);
    is_select = b[7:4] == nib;
  endfunction

  assign clear = SYS_RST || !RESET_PIN_N;
  assign fire_enabled = FIRE_ENABLE_IN_ONE && FIRE_ENABLE_IN_TWO;
  assign fire_any = FIRE_ENABLE_IN_ONE || FIRE_ENABLE_IN_TWO;
  assign sclk_rise = SCLK && !sclk_prev;
  assign sclk_fall = !SCLK && sclk_prev;
  assign frame_start = cs_prev && !CS_N;
  assign frame_end = !cs_prev && CS_N;

  // unlock only while both fire enables are low
  assign unlock_ok = frame.valid && is_unlock(frame.data) && !fire_any;
  assign sel_high_ok = frame.valid && unlock_state == UNLOCK_HIGH
    && is_select(frame.data, `SEL_HIGH_NIBBLE);
  assign sel_low_ok = frame.valid && unlock_state == UNLOCK_LOW
    && is_select(frame.data, `SEL_LOW_NIBBLE);

  // serial edge tracking
  always_ff @(posedge CLOCK)
  begin
    if (clear)
    begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end
    else
    begin
      sclk_prev <= SCLK;
      cs_prev <= CS_N;
    end
  end

  // receive shifter and bit count
  always_ff @(posedge CLOCK)
  begin
    if (clear)
    begin
      rx_shift <= 8'h00;
      bit_count <= 4'h0;
    end
    else if (frame_start)
    begin
      rx_shift <= 8'h00;
      bit_count <= 4'h0;
    end
    else if (!CS_N && sclk_rise)
    begin
      rx_shift <= {rx_shift[6:0], MOSI};
      if (bit_count != 4'hF)
        bit_count <= bit_count + 4'h1;
    end
  end

  // a frame counts only with exactly eight bits
  always_ff @(posedge CLOCK)
  begin
    if (clear)
      frame <= '0;
    else
    begin
      frame.valid <= frame_end && bit_count == `FRAME_BITS;
      frame.data <= rx_shift;
    end
  end

  // transmit byte chosen at frame start
  always_comb
  begin
    unique case (reply_kind)
      REPLY_IDLE: reply_byte = `REPLY_IDLE_BYTE;
      REPLY_ECHO: reply_byte = echo_byte;
      REPLY_THERMAL: reply_byte = 8'(thermal_latch);
      REPLY_TEST: reply_byte = test_fail;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (clear)
    begin
      tx_shift <= 8'h00;
      MISO <= 1'b0;
      MISO_OE <= 1'b0;
      reply_now <= REPLY_IDLE;
    end
    else if (frame_start)
    begin
      tx_shift <= reply_byte;
      MISO <= reply_byte[7];
      MISO_OE <= 1'b1;
      reply_now <= reply_kind;
    end
    else if (CS_N)
    begin
      MISO <= 1'b0;
      MISO_OE <= 1'b0;
    end
    else if (sclk_fall)
    begin
      tx_shift <= {tx_shift[6:0], 1'b0};
      MISO <= tx_shift[6];
    end
  end

  // reply for the next frame
  always_ff @(posedge CLOCK)
  begin
    if (clear)
    begin
      reply_kind <= REPLY_IDLE;
      echo_byte <= 8'h00;
    end
    else if (frame.valid)
    begin
      echo_byte <= frame.data;
      if (is_unlock(frame.data))
        reply_kind <= REPLY_ECHO;
      else if (frame.data == `CMD_THERMAL && unlock_state == UNLOCK_NONE)
        reply_kind <= REPLY_THERMAL;
      else if (sel_high_ok || sel_low_ok)
        reply_kind <= REPLY_TEST;
      else
        reply_kind <= REPLY_IDLE;
    end
  end

  // thermal status latch
  always_ff @(posedge CLOCK)
  begin
    if (clear)
      thermal_latch <= '0;
    else if (frame.valid)
    begin
      if (frame.data == `CMD_THERMAL && unlock_state == UNLOCK_NONE)
        thermal_latch <= thermal_flag;
      else if (unlock_ok)
        thermal_latch <= '0;
      else if (reply_now == REPLY_THERMAL)
        thermal_latch <= '0;
    end
  end

  // unlock sequencing
  always_ff @(posedge CLOCK)
  begin
    if (clear)
      unlock_state <= UNLOCK_NONE;
    else if (fire_any)
      unlock_state <= UNLOCK_NONE;
    else if (frame.valid)
    begin
      if (unlock_ok && frame.data == `CMD_UNLOCK_HIGH)
        unlock_state <= UNLOCK_HIGH;
      else if (unlock_ok)
        unlock_state <= UNLOCK_LOW;
      else
        unlock_state <= UNLOCK_NONE;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (clear)
      DIAG_BLOCKED <= 1'b0;
    else if (fire_any)
      DIAG_BLOCKED <= 1'b0;
    else if (frame.valid)
      DIAG_BLOCKED <= unlock_ok;
  end

  // test enables; ended only by host commands, a high fire enable or reset
  always_ff @(posedge CLOCK)
  begin
    if (clear)
      test_active <= '0;
    else if (fire_any)
      test_active <= '0;
    else if (frame.valid && is_unlock(frame.data))
      test_active <= '0;
    else if (sel_high_ok)
      test_active <= '{high: frame.data[3:0], low: 4'h0};
    else if (sel_low_ok)
      test_active <= '{high: 4'h0, low: frame.data[3:0]};
  end

  // fail bits: set at selection, cleared once the driver is seen on
  always_ff @(posedge CLOCK)
  begin
    if (clear)
      test_fail <= '0;
    else if (unlock_ok)
      test_fail <= '0;
    else if (sel_high_ok)
      test_fail <= '{high: frame.data[3:0], low: 4'h0};
    else if (sel_low_ok)
      test_fail <= '{high: 4'h0, low: frame.data[3:0]};
    else
    begin
      test_fail.high <= test_fail.high & ~(test_active.high & HIGH_SIDE_ON_SENSE);
      test_fail.low <= test_fail.low & ~(test_active.low & LOW_SIDE_ON_SENSE);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (clear)
    begin
      HIGH_SIDE_TEST_EN <= '0;
      LOW_SIDE_TEST_EN <= '0;
      TEST_CURRENT_LIMIT <= 1'b0;
    end
    else
    begin
      HIGH_SIDE_TEST_EN <= test_active.high;
      LOW_SIDE_TEST_EN <= test_active.low;
      TEST_CURRENT_LIMIT <= |test_active;
    end
  end

  // per-channel firing and thermal guard
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      on_time_guard #(
        .MIN_CYCLES(THERM_MIN_CYCLES),
        .MAX_CYCLES(THERM_MAX_CYCLES),
        .WIDTH(`ON_COUNT_WIDTH)
      ) u_guard (
        .clk(CLOCK),
        .clear(clear),
        .drive_on(DRIVE_ON[ch]),
        .overtemp(OVERTEMP[ch]),
        .shorted_load(SHORTED_LOAD[ch]),
        .shutdown(shutdown[ch])
      );

      always_ff @(posedge CLOCK)
      begin
        if (clear)
          thermal_flag[ch] <= 1'b0;
        else if (shutdown[ch])
          thermal_flag[ch] <= 1'b1;
        else if (!OVERTEMP[ch])
          thermal_flag[ch] <= 1'b0;
      end

      always_ff @(posedge CLOCK)
      begin
        if (clear)
          DRIVE_ON[ch] <= 1'b0;
        else
          DRIVE_ON[ch] <= FIRE_CMD[ch] && fire_enabled
            && !thermal_flag[ch] && !shutdown[ch];
      end

      always_ff @(posedge CLOCK)
      begin
        if (clear)
          THERMAL_STATUS[ch] <= 1'b0;
        else
          THERMAL_STATUS[ch] <= thermal_flag[ch] || shutdown[ch];
      end
    end
  endgenerate
endmodule

// file: dv/squib_diag_assertions.sv
module squib_diag_assertions
  import squib_diag_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  // clock and resets
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic RESET_PIN_N,
  // serial port
  input wire logic CS_N,
  input wire logic MISO,
  input wire logic MISO_OE,
  // enables and drives
  input wire logic FIRE_ENABLE_IN_ONE,
  input wire logic FIRE_ENABLE_IN_TWO,
  input wire logic [CHANNELS-1:0] DRIVE_ON,
  input wire logic [CHANNELS-1:0] THERMAL_STATUS,
  input wire logic [CHANNELS-1:0] HIGH_SIDE_TEST_EN,
  input wire logic [CHANNELS-1:0] LOW_SIDE_TEST_EN,
  input wire logic TEST_CURRENT_LIMIT,
  input wire logic DIAG_BLOCKED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST || !RESET_PIN_N);
  wire logic test_on = (|HIGH_SIDE_TEST_EN) || (|LOW_SIDE_TEST_EN);

  a_no_mixed_test: assert property (!(|HIGH_SIDE_TEST_EN && |LOW_SIDE_TEST_EN))
    else $error("high and low test drives on together");
  a_enable_aborts: assert property ((FIRE_ENABLE_IN_ONE || FIRE_ENABLE_IN_TWO) |-> ##2 !test_on)
    else $error("test drive kept while fire enable high");
  a_test_limit: assert property ($rose(test_on) |-> ##[0:1] TEST_CURRENT_LIMIT)
    else $error("test drive without test current limit");
  a_fire_gated: assert property (DRIVE_ON != 0 |->
    $past(FIRE_ENABLE_IN_ONE) && $past(FIRE_ENABLE_IN_TWO))
    else $error("drive on without both fire enables");
  a_hot_no_drive: assert property ((DRIVE_ON & THERMAL_STATUS & $past(THERMAL_STATUS)) == 0)
    else $error("driver on while thermal flag set");
  a_miso_quiet: assert property (CS_N [*3] |-> !MISO_OE && !MISO)
    else $error("serial output active outside frame");
  a_test_frame_end: assert property ($rose(test_on) |-> CS_N && $past(CS_N, 3))
    else $error("test drive started inside a frame");
  a_unlock_stops: assert property ($rose(DIAG_BLOCKED) |-> ##1 !test_on)
    else $error("unlock did not stop the test");
  a_oe_in_frame: assert property (!CS_N [*2] |-> MISO_OE)
    else $error("serial output not driven inside frame");
endmodule

// file: dv/spi_host_model.sv
module spi_host_model
(
  // serial port
  input wire logic CLOCK,
  output logic SCLK,
  output logic CS_N,
  output logic MOSI,
  input wire logic MISO
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // n bits msb first in one select, reply sampled at each rising sclk
  task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge CLOCK) CS_N = 1'b0;
    repeat (2) @(negedge CLOCK);
    for (int i = 7; i > 7 - n; i--)
    begin
      MOSI = tx[i];
      repeat (2) @(negedge CLOCK);
      SCLK = 1'b1;
      rx[i] = MISO;
      repeat (2) @(negedge CLOCK);
      SCLK = 1'b0;
    end
    repeat (2) @(negedge CLOCK);
    CS_N = 1'b1;
    // released line shows no stale bit
    MOSI = ~MOSI;
    repeat (6) @(negedge CLOCK);
  endtask
endmodule

// file: dv/squib_diag_tb_top.sv
module squib_diag_tb_top;
  import squib_diag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, RESET_PIN_N = 1'b1, FEN1 = 1'b0, FEN2 = 1'b0;
  logic SCLK, CS_N, MOSI, MISO, MISO_OE, TEST_CURRENT_LIMIT, DIAG_BLOCKED;
  logic [3:0] FIRE_CMD = 4'h0, OVERTEMP = 4'h0, SHORTED = 4'h0, HS_SENSE = 4'h0;
  logic [3:0] LS_SENSE = 4'h0, DRIVE_ON, THERMAL_STATUS, HS_EN, LS_EN;
  logic [7:0] rx;
  int num_errors = 0;
  int total_checks = 0;
  always #4 CLOCK = ~CLOCK;

  squib_diag #(.THERM_MIN_CYCLES(20), .THERM_MAX_CYCLES(30)) squib_diag_i (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .RESET_PIN_N(RESET_PIN_N), .SCLK(SCLK),
    .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE),
    .FIRE_ENABLE_IN_ONE(FEN1), .FIRE_ENABLE_IN_TWO(FEN2), .FIRE_CMD(FIRE_CMD),
    .OVERTEMP(OVERTEMP), .SHORTED_LOAD(SHORTED), .HIGH_SIDE_ON_SENSE(HS_SENSE),
    .LOW_SIDE_ON_SENSE(LS_SENSE), .DRIVE_ON(DRIVE_ON), .HIGH_SIDE_TEST_EN(HS_EN),
    .LOW_SIDE_TEST_EN(LS_EN), .TEST_CURRENT_LIMIT(TEST_CURRENT_LIMIT),
    .THERMAL_STATUS(THERMAL_STATUS), .DIAG_BLOCKED(DIAG_BLOCKED));
  spi_host_model spi_host_model_i (.CLOCK(CLOCK), .SCLK(SCLK), .CS_N(CS_N),
    .MOSI(MOSI), .MISO(MISO));

  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] tx, input logic [7:0] exp);
    spi_host_model_i.xfer(8, tx, rx);
    chk(rx, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge CLOCK);
  endtask

  initial
  begin
    repeat (5000) @(posedge CLOCK);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    step(12);
    SYS_RST = 1'b0;
    step(2);
    cmd(8'h00, 8'h00);
    // firing with one hot channel and one shorted channel
    FEN1 = 1'b1;
    FEN2 = 1'b1;
    FIRE_CMD = 4'hF;
    OVERTEMP = 4'h1;
    SHORTED = 4'h2;
    step(10);
    chk(8'(DRIVE_ON), 8'h0F);
    step(15);
    chk(8'(DRIVE_ON), 8'h0E);
    step(9);
    chk(8'(DRIVE_ON), 8'h0C);
    SHORTED = 4'h0;
    step(20);
    chk(8'(THERMAL_STATUS), 8'h01);
    chk(8'(DRIVE_ON), 8'h0E);
    cmd(8'h7F, 8'h00);
    cmd(8'h00, 8'h01);
    cmd(8'h00, 8'h00);
    OVERTEMP = 4'h0;
    step(4);
    chk(8'(THERMAL_STATUS), 8'h00);
    chk(8'(DRIVE_ON), 8'h0F);
    FIRE_CMD = 4'h0;
    FEN1 = 1'b0;
    FEN2 = 1'b0;
    // high and low side tests, a short frame in between is ignored
    HS_SENSE = 4'h3;
    cmd(8'h82, 8'h00);
    chk(8'(DIAG_BLOCKED), 8'h01);
    spi_host_model_i.xfer(5, 8'h15, rx);
    chk(8'(DIAG_BLOCKED), 8'h01);
    cmd(8'h15, 8'h82);
    chk(8'(HS_EN), 8'h05);
    chk(8'(TEST_CURRENT_LIMIT), 8'h01);
    chk(8'(DIAG_BLOCKED), 8'h00);
    cmd(8'h83, 8'h40);
    chk(8'(HS_EN), 8'h00);
    cmd(8'h2A, 8'h83);
    chk(8'(LS_EN), 8'h0A);
    FEN1 = 1'b1;
    step(3);
    chk(8'(LS_EN), 8'h00);
    FEN1 = 1'b0;
    cmd(8'h00, 8'h0A);
    // unlock refused while an enable is high
    FEN2 = 1'b1;
    cmd(8'h82, 8'h00);
    cmd(8'h15, 8'h82);
    chk(8'(HS_EN), 8'h00);
    FEN2 = 1'b0;
    // reset pin ends a running test
    cmd(8'h82, 8'h00);
    cmd(8'h11, 8'h82);
    chk(8'(HS_EN), 8'h01);
    RESET_PIN_N = 1'b0;
    step(2);
    chk(8'(HS_EN), 8'h00);
    RESET_PIN_N = 1'b1;
    step(2);
    print_verdict();
  end
endmodule

bind squib_diag squib_diag_assertions #(.CHANNELS(CHANNELS)) squib_diag_assertions_i (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .RESET_PIN_N(RESET_PIN_N), .CS_N(CS_N),
  .MISO(MISO), .MISO_OE(MISO_OE), .FIRE_ENABLE_IN_ONE(FIRE_ENABLE_IN_ONE),
  .FIRE_ENABLE_IN_TWO(FIRE_ENABLE_IN_TWO), .DRIVE_ON(DRIVE_ON),
  .THERMAL_STATUS(THERMAL_STATUS), .HIGH_SIDE_TEST_EN(HIGH_SIDE_TEST_EN),
  .LOW_SIDE_TEST_EN(LOW_SIDE_TEST_EN), .TEST_CURRENT_LIMIT(TEST_CURRENT_LIMIT),
  .DIAG_BLOCKED(DIAG_BLOCKED));
